// ==== rtl/dma_pair.sv ====
// Operation
// - Two cascaded controllers, four 8-bit, three 16-bit
// - 16-bit channel 0 is cascade link
// - 8-bit controller drives addresses for four channels, 16-bit for three
// - Always idle, program or active; idle first
// - Idle samples requests; index port access wins
// - Active first wins PCI bus
// - Acknowledge highest priority only after grant
// - Controller drives ISA strobes and ready handling
// - Index port access enters program state
// - Per-channel single, block, demand, cascade mode
// - Single moves one unit, then rearbitrates
// - Count decrements; zero reloads or masks
// - Block holds bus until count zero
// - Demand runs until zero or request drops
// - Held demand request gives back-to-back transfers
// - Cascade channel passes hold, keeps rotation
// - Read, write, verify in single, block, demand mode
// - Autoinit restores address, count on completion
// - Autoinit channel is not masked
// - Type A, B, F cycle timings
`timescale 1ns/1ps
`include "dma_pair_params.svh"
module dma_pair
  import dma_pair_pkg::*;
#(
  parameter int NCH        = 8,
  parameter int FIFO_DEPTH = `FIFO_DEPTH_DEF
) (
  input  wire logic            CORE_CLK,
  input  wire logic            RST_B,
  input  wire logic            IO_SEL,
  input  wire logic            IO_WR,
  input  wire logic [7:0]      IO_ADDR,
  input  wire logic [7:0]      IO_WDATA,
  output logic      [7:0]      IO_RDATA,
  input  wire logic [NCH-1:0]  DREQ,
  output logic      [NCH-1:0]  DACK,
  input  wire logic            END_OF_PROCESS_INPUT,
  output logic                 PCI_REQ,
  input  wire logic            PCI_GNT,
  output logic      [15:0]     MEM_ADDR,
  output logic                 MEM_WIDE,
  output logic                 ISA_IOR_B,
  output logic                 ISA_IOW_B,
  input  wire logic            IOCHRDY,
  input  wire logic [15:0]     ISA_DATA_IN,
  output logic      [15:0]     XFER_DATA,
  output logic                 XFER_VALID,
  input  wire logic            XFER_READY,
  output logic      [2:0]      ENGINE_STATE
);
  logic rst_s1_q, rst_n;
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      rst_s1_q <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n    <= rst_s1_q;
    end
  end

  engine_state_type state_q, state_d;
  logic [7:0]  index_q, index_d;
  logic [15:0] base_addr_q [NCH];
  logic [15:0] base_count_q [NCH];
  logic [15:0] cur_addr_q [NCH], cur_addr_d [NCH];
  logic [15:0] remaining_transfer_count_q [NCH], remaining_transfer_count_d [NCH];
  logic [7:0]  mode_q [NCH], mode_d [NCH];
  logic [NCH-1:0] mask_q, mask_d, tc_q, tc_d;
  logic [2:0]  chan_q, chan_d, prio_q, prio_d;
  logic [3:0]  wait_q, wait_d;
  logic        strobe_q, strobe_d;
  logic [NCH-1:0] ack_q, ack_d;
  logic        cfg_hit, idx_hit, data_hit, fifo_in_ready;
  logic [NCH-1:0] pending;
  logic [2:0]  winner;
  logic        found;
  logic [2:0]  ich;
  logic [3:0]  ireg;
  xfer_mode_type cmode;
  xfer_type_type ctype;
  logic        last, done, wr_unit;

  assign idx_hit  = IO_SEL && (IO_ADDR == `CFG_INDEX_PORT_ADDR);
  assign data_hit = IO_SEL && (IO_ADDR == `CFG_DATA_PORT_ADDR);
  assign cfg_hit  = idx_hit || data_hit;
  assign ich      = index_q[6:4];
  assign ireg     = index_q[3:0];
  assign cmode    = xfer_mode_type'(mode_q[chan_q][`MODE_XFER_LSB +: 2]);
  assign ctype    = xfer_type_type'(mode_q[chan_q][`MODE_TYPE_LSB +: 2]);

  // Slot 4 is the cascade link; it never requests on its own.
  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      pending[i] = DREQ[i] && !mask_q[i] && (i != int'(`CASCADE_CHANNEL));
    end
  end

  // Rotating priority: search starts one past the last served channel.
  always_comb begin
    winner = 3'h0;
    found  = 1'b0;
    for (int k = 0; k < NCH; k++) begin
      if (!found && pending[3'(prio_q + 3'(k))]) begin
        winner = 3'(prio_q + 3'(k));
        found  = 1'b1;
      end
    end
  end

  always_comb begin
    state_d  = state_q;
    index_d  = index_q;
    chan_d   = chan_q;
    prio_d   = prio_q;
    wait_d   = wait_q;
    strobe_d = 1'b0;
    ack_d    = ack_q;
    mask_d   = mask_q;
    tc_d     = tc_q;
    wr_unit  = 1'b0;
    last     = 1'b0;
    done     = 1'b0;
    for (int i = 0; i < NCH; i++) begin
      cur_addr_d[i]                 = cur_addr_q[i];
      remaining_transfer_count_d[i] = remaining_transfer_count_q[i];
      mode_d[i]                     = mode_q[i];
    end
    case (state_q)
      ST_IDLE: begin
        // Index port access served before any request.
        if (idx_hit) begin
          state_d = ST_PROGRAM;
        end else if (found) begin
          state_d = ST_ACTIVE;
          chan_d  = winner;
        end
      end
      ST_PROGRAM: begin
        if (idx_hit && IO_WR) begin
          index_d = IO_WDATA;
        end else if (data_hit && IO_WR) begin
          case (ireg)
            `IDX_MODE: mode_d[ich] = IO_WDATA;
            `IDX_MASK: mask_d[ich] = IO_WDATA[0];
            default: ;
          endcase
          state_d = ST_IDLE;
        end else if (data_hit) begin
          if (ireg == `IDX_STATUS) begin
            tc_d[ich] = 1'b0;
          end
          state_d = ST_IDLE;
        end else if (!cfg_hit) begin
          state_d = ST_IDLE;
        end
      end
      ST_ACTIVE: begin
        // Bus ownership must precede acknowledge.
        if (!PCI_GNT) begin
          ack_d = '0;
        end else if (ack_q == '0) begin
          ack_d[chan_q] = 1'b1;
          case (mode_q[chan_q][`MODE_TIMING_LSB +: 2])
            2'h0: wait_d = `TYPE_A_WAIT;
            2'h1: wait_d = `TYPE_B_WAIT;
            default: wait_d = `TYPE_F_WAIT;
          endcase
        end else if (cmode == XFER_CASCADE) begin
          // External hold request keeps the acknowledge up.
          if (!DREQ[chan_q]) begin
            ack_d   = '0;
            prio_d  = 3'(chan_q + 3'h1);
            state_d = ST_IDLE;
          end
        end else if (wait_q != 4'h0) begin
          wait_d   = 4'(wait_q - 4'h1);
          strobe_d = 1'b1;
        end else if (IOCHRDY && fifo_in_ready) begin
          // Peripheral or FIFO stall simply stretches the cycle.
          wr_unit = (ctype == TYPE_WRITE);
          remaining_transfer_count_d[chan_q] =
            16'(remaining_transfer_count_q[chan_q] - 16'h1);
          cur_addr_d[chan_q] = 16'(cur_addr_q[chan_q] + 16'h1);
          last = (remaining_transfer_count_q[chan_q] == 16'h0) || END_OF_PROCESS_INPUT;
          case (mode_q[chan_q][`MODE_XFER_LSB +: 2])
            XFER_SINGLE: done = 1'b1;
            XFER_BLOCK:  done = last;
            XFER_DEMAND: done = last || !DREQ[chan_q];
            default:     done = 1'b1;
          endcase
          if (last) begin
            tc_d[chan_q] = 1'b1;
            if (mode_q[chan_q][`MODE_AUTO_BIT]) begin
              cur_addr_d[chan_q] = base_addr_q[chan_q];
              remaining_transfer_count_d[chan_q] = base_count_q[chan_q];
            end else begin
              mask_d[chan_q] = 1'b1;
            end
          end
          if (done) begin
            ack_d   = '0;
            prio_d  = 3'(chan_q + 3'h1);
            state_d = ST_IDLE;
          end else begin
            case (mode_q[chan_q][`MODE_TIMING_LSB +: 2])
              2'h0: wait_d = `TYPE_A_WAIT;
              2'h1: wait_d = `TYPE_B_WAIT;
              default: wait_d = `TYPE_F_WAIT;
            endcase
          end
        end else begin
          strobe_d = 1'b1;
        end
      end
      default: state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      state_q  <= ST_IDLE;
      index_q  <= 8'h00;
      chan_q   <= 3'h0;
      prio_q   <= 3'h0;
      wait_q   <= 4'h0;
      strobe_q <= 1'b0;
      ack_q    <= '0;
      mask_q   <= '1;
      tc_q     <= '0;
      for (int i = 0; i < NCH; i++) begin
        cur_addr_q[i]                 <= 16'h0000;
        remaining_transfer_count_q[i] <= 16'h0000;
        base_addr_q[i]                <= 16'h0000;
        base_count_q[i]               <= 16'h0000;
        mode_q[i]                     <= 8'h00;
      end
    end else begin
      state_q  <= state_d;
      index_q  <= index_d;
      chan_q   <= chan_d;
      prio_q   <= prio_d;
      wait_q   <= wait_d;
      strobe_q <= strobe_d;
      ack_q    <= ack_d;
      mask_q   <= mask_d;
      tc_q     <= tc_d;
      for (int i = 0; i < NCH; i++) begin
        cur_addr_q[i]                 <= cur_addr_d[i];
        remaining_transfer_count_q[i] <= remaining_transfer_count_d[i];
        mode_q[i]                     <= mode_d[i];
      end
      // Address and count writes load base and current copies together
      if (state_q == ST_PROGRAM && data_hit && IO_WR) begin
        case (ireg)
          `IDX_ADDR_LO: begin
            base_addr_q[ich][7:0] <= IO_WDATA;
            cur_addr_q[ich][7:0]  <= IO_WDATA;
          end
          `IDX_ADDR_HI: begin
            base_addr_q[ich][15:8] <= IO_WDATA;
            cur_addr_q[ich][15:8]  <= IO_WDATA;
          end
          `IDX_COUNT_LO: begin
            base_count_q[ich][7:0]               <= IO_WDATA;
            remaining_transfer_count_q[ich][7:0] <= IO_WDATA;
          end
          `IDX_COUNT_HI: begin
            base_count_q[ich][15:8]               <= IO_WDATA;
            remaining_transfer_count_q[ich][15:8] <= IO_WDATA;
          end
          default: ;
        endcase
      end
    end
  end

  always_comb begin
    case (ireg)
      `IDX_ADDR_LO:  IO_RDATA = cur_addr_q[ich][7:0];
      `IDX_ADDR_HI:  IO_RDATA = cur_addr_q[ich][15:8];
      `IDX_COUNT_LO: IO_RDATA = remaining_transfer_count_q[ich][7:0];
      `IDX_COUNT_HI: IO_RDATA = remaining_transfer_count_q[ich][15:8];
      `IDX_MODE:     IO_RDATA = mode_q[ich];
      `IDX_MASK:     IO_RDATA = {7'h00, mask_q[ich]};
      `IDX_STATUS:   IO_RDATA = {7'h00, tc_q[ich]};
      default:       IO_RDATA = 8'h00;
    endcase
  end

  // Channels 4..7 sit on the 16-bit controller, word addressed.
  assign MEM_WIDE     = chan_q[2];
  assign MEM_ADDR     = cur_addr_q[chan_q];
  assign PCI_REQ      = (state_q == ST_ACTIVE);
  assign DACK         = ack_q;
  // Verify cycles run the count but pulse neither strobe.
  assign ISA_IOR_B    = !(strobe_q && ctype == TYPE_WRITE);
  assign ISA_IOW_B    = !(strobe_q && ctype == TYPE_READ);
  assign ENGINE_STATE = state_q;

  dma_pair_fifo #(.WIDTH(16), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk       (CORE_CLK),
    .rst_n     (rst_n),
    .in_data   (ISA_DATA_IN),
    .in_valid  (wr_unit),
    .in_ready  (fifo_in_ready),
    .out_data  (XFER_DATA),
    .out_valid (XFER_VALID),
    .out_ready (XFER_READY)
  );

  chk_ack_needs_grant: assert property (@(posedge CORE_CLK) disable iff (!rst_n)
    (ack_q != '0) |-> $past(PCI_GNT)) else $error("ack without grant");
  chk_idle_cfg_first: assert property (@(posedge CORE_CLK) disable iff (!rst_n)
    (state_q == ST_IDLE && idx_hit) |=> state_q == ST_PROGRAM)
    else $error("config not first");
  chk_onehot_state: assert property (@(posedge CORE_CLK) disable iff (!rst_n)
    $onehot(state_q)) else $error("bad state");
  chk_cascade_no_ack: assert property (@(posedge CORE_CLK) disable iff (!rst_n)
    !ack_q[`CASCADE_CHANNEL]) else $error("cascade slot acked");
  chk_active_req_bus: assert property (@(posedge CORE_CLK) disable iff (!rst_n)
    (state_q == ST_ACTIVE) |-> PCI_REQ) else $error("no bus request");
  chk_single_release: assert property (@(posedge CORE_CLK) disable iff (!rst_n)
    (state_q == ST_ACTIVE && done && cmode == XFER_SINGLE) |=> state_q == ST_IDLE)
    else $error("single kept bus");
  chk_tc_mask_noauto: assert property (@(posedge CORE_CLK) disable iff (!rst_n)
    (last && !mode_q[chan_q][`MODE_AUTO_BIT]) |=> mask_q[$past(chan_q)])
    else $error("not masked");
  chk_auto_reload: assert property (@(posedge CORE_CLK) disable iff (!rst_n)
    (last && mode_q[chan_q][`MODE_AUTO_BIT]) |=> !mask_q[$past(chan_q)]
      && cur_addr_q[$past(chan_q)] == base_addr_q[$past(chan_q)])
    else $error("no reload");
  chk_verify_quiet: assert property (@(posedge CORE_CLK) disable iff (!rst_n)
    (ctype == TYPE_VERIFY) |-> ISA_IOR_B && ISA_IOW_B) else $error("verify strobed");
endmodule

// ==== rtl/dma_pair_params.svh ====
`ifndef DMA_PAIR_PARAMS_SVH
`define DMA_PAIR_PARAMS_SVH
`define CFG_INDEX_PORT_ADDR 8'h22
`define CFG_DATA_PORT_ADDR  8'h23
`define IDX_CH_SHIFT        3'h4
`define IDX_ADDR_LO         4'h0
`define IDX_ADDR_HI         4'h1
`define IDX_COUNT_LO        4'h2
`define IDX_COUNT_HI        4'h3
`define IDX_MODE            4'h4
`define IDX_MASK            4'h5
`define IDX_STATUS          4'h6
`define MODE_XFER_LSB       0
`define MODE_TYPE_LSB       2
`define MODE_AUTO_BIT       4
`define MODE_TIMING_LSB     5
`define CASCADE_CHANNEL     3'h4
`define TYPE_A_WAIT         4'h3
`define TYPE_B_WAIT         4'h2
`define TYPE_F_WAIT         4'h0
`define FIFO_DEPTH_DEF      16
`endif

// ==== rtl/dma_pair_pkg.sv ====
package dma_pair_pkg;
  typedef enum logic [2:0] {
    ST_IDLE    = 3'b001,
    ST_PROGRAM = 3'b010,
    ST_ACTIVE  = 3'b100
  } engine_state_type;
  typedef enum logic [1:0] {
    XFER_DEMAND  = 2'h0,
    XFER_SINGLE  = 2'h1,
    XFER_BLOCK   = 2'h2,
    XFER_CASCADE = 2'h3
  } xfer_mode_type;
  typedef enum logic [1:0] {
    TYPE_VERIFY = 2'h0,
    TYPE_WRITE  = 2'h1,
    TYPE_READ   = 2'h2
  } xfer_type_type;
endpackage

// ==== rtl/dma_pair_fifo.sv ====
`timescale 1ns/1ps
module dma_pair_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic      [WIDTH-1:0] out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_q, wr_d, rd_q, rd_d;
  logic [AW:0]      cnt_q, cnt_d;
  logic             push, pop;
  assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign out_data  = mem[rd_q];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  always_comb begin
    wr_d  = push ? AW'(wr_q + 1'b1) : wr_q;
    rd_d  = pop ? AW'(rd_q + 1'b1) : rd_q;
    cnt_d = (AW+1)'(cnt_q + {AW'(0), push} - {AW'(0), pop});
  end
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_q] <= in_data;
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      wr_q  <= wr_d;
      rd_q  <= rd_d;
      cnt_q <= cnt_d;
    end
  end
endmodule

// ==== verif/dma_pair_far_side.sv ====
`timescale 1ns/1ps
module dma_pair_far_side (
  input  wire logic        clk,
  input  wire logic        pci_req,
  input  wire logic [7:0]  dack,
  input  wire logic [3:0]  gnt_delay,
  output logic             pci_gnt,
  output logic             iochrdy,
  output logic      [15:0] isa_data
);
  logic [3:0] wait_q;
  logic       t_q;
  initial begin
    {pci_gnt, iochrdy, t_q} = 3'b010;
    wait_q = 4'h0;
    isa_data = 16'h0000;
  end
  // Grant after a delay; withdrawn once the request drops
  always @(posedge clk) begin
    t_q <= ~t_q;
    if (!pci_req) wait_q <= 4'h0;
    else if (wait_q != 4'hf) wait_q <= wait_q + 4'h1;
    pci_gnt <= pci_req && wait_q >= gnt_delay;
    // A slow peripheral stretches every other cycle
    iochrdy <= !(gnt_delay != 4'h0 && dack != 8'h00 && t_q);
    // Released lines never keep the last value
    isa_data <= (dack != 8'h00) ? 16'h5a3c : ~isa_data;
  end
endmodule

// ==== verif/dma_pair_test.sv ====
`timescale 1ns/1ps
`include "dma_pair_params.svh"
module dma_pair_test;
  import dma_pair_pkg::*;
  typedef struct {
    logic [2:0]    ch;
    xfer_mode_type xm;
    xfer_type_type ty;
    logic          au;
    logic [1:0]    tm;
    logic [7:0]    cnt;
    int            rises;
    int            words;
  } row_type;
  logic        clk = 0, rst_b = 0, io_sel = 0, io_wr = 0, eop = 0, xr = 1;
  logic        pci_req, pci_gnt, iochrdy, mem_wide, ior_b, iow_b, xv, req_q = 0, won = 0;
  logic [7:0]  io_addr = 0, io_wdata = 0, dreq = 0, io_rdata, dack, v;
  logic [15:0] isa_din, mem_addr, xd, xd_q;
  logic [2:0]  state;
  logic [3:0]  gdly = 0;
  int          err_total = 0, n_checks = 0, cyc = 0, rises = 0, words = 0;
  int          stop_at = 0, ior_n = 0, iow_n = 0;
  row_type     rows[7], r;

  dma_pair uut (
    .CORE_CLK(clk), .RST_B(rst_b), .IO_SEL(io_sel), .IO_WR(io_wr), .IO_ADDR(io_addr),
    .IO_WDATA(io_wdata), .IO_RDATA(io_rdata), .DREQ(dreq), .DACK(dack),
    .END_OF_PROCESS_INPUT(eop), .PCI_REQ(pci_req), .PCI_GNT(pci_gnt), .MEM_ADDR(mem_addr),
    .MEM_WIDE(mem_wide), .ISA_IOR_B(ior_b), .ISA_IOW_B(iow_b), .IOCHRDY(iochrdy),
    .ISA_DATA_IN(isa_din), .XFER_DATA(xd), .XFER_VALID(xv), .XFER_READY(xr),
    .ENGINE_STATE(state)
  );
  dma_pair_far_side far (
    .clk(clk), .pci_req(pci_req), .dack(dack), .gnt_delay(gdly),
    .pci_gnt(pci_gnt), .iochrdy(iochrdy), .isa_data(isa_din)
  );

  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    n_checks++;
    if (s !== e) begin
      err_total++;
      $display("unexpected at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic summarize;
    $display("checks %0d, mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // Called at a falling edge; leaves the select up so accesses run back to back
  task automatic io(input logic [7:0] a, input logic [7:0] d, input logic w);
    {io_sel, io_wr, io_addr, io_wdata} = {1'b1, w, a, d};
    #10 v = io_rdata;
    @(negedge clk);
  endtask
  task automatic cfg(input logic [2:0] ch, input logic [3:0] rg, input logic [7:0] d,
                     input logic w);
    io(`CFG_INDEX_PORT_ADDR, {1'b0, ch, rg}, 1'b1);
    io(`CFG_INDEX_PORT_ADDR, {1'b0, ch, rg}, 1'b1);
    io(`CFG_DATA_PORT_ADDR, d, w);
    io_sel = 1'b0;
    @(negedge clk);
  endtask
  task automatic prog(input logic [2:0] ch, input logic [7:0] m, input logic [7:0] c);
    cfg(ch, `IDX_COUNT_LO, c, 1'b1);
    cfg(ch, `IDX_COUNT_HI, 8'h00, 1'b1);
    cfg(ch, `IDX_MODE, m, 1'b1);
    cfg(ch, `IDX_MASK, 8'h00, 1'b1);
    {rises, words, ior_n, iow_n} = '0;
  endtask
  // Quiet for 20 cycles also lets the buffer drain
  task automatic settle;
    int q;
    q = 0;
    for (int i = 0; i < 3000 && q < 20; i++) begin
      @(negedge clk);
      q = (state === ST_IDLE) ? q + 1 : 0;
    end
    chk(q, 20);
  endtask
  task automatic wait_dack(input logic [7:0] d);
    for (int i = 0; i < 200 && dack !== d; i++) @(negedge clk);
  endtask
  task automatic do_reset;
    rst_b = 1'b0;
    repeat (3) @(negedge clk);
    chk({dack, state, ior_b, iow_b}, {8'h00, ST_IDLE, 2'b11});
    rst_b = 1'b1;
    repeat (4) @(negedge clk);
  endtask

  initial begin
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (pci_req === 1'b1 && req_q !== 1'b1) rises++;
    if (xv === 1'b1 && xr === 1'b1) begin
      words++;
      xd_q <= xd;
    end
    if (ior_b === 1'b0) ior_n++;
    if (iow_b === 1'b0) iow_n++;
    req_q <= pci_req;
    won <= (pci_req && pci_gnt) || (won && (pci_req || dack != 8'h00));
    if (dack !== 8'h00 && rst_b === 1'b1) begin
      chk(won, 1'b1);
      chk($countones(dack), 1);
      chk(mem_wide, dack[7:5] != 3'h0);
    end
    if (cyc == 40000) begin
      err_total++;
      summarize();
    end
  end
  // Single mode: drop the request during the last wanted unit
  always @(negedge clk) begin
    if (stop_at != 0 && rises >= stop_at && dack !== 8'h00) dreq = 8'h00;
  end

  initial begin
    rows = '{'{3'h1, XFER_BLOCK,  TYPE_WRITE,  1'b0, 2'h0, 8'h03, 1, 4},
             '{3'h2, XFER_DEMAND, TYPE_VERIFY, 1'b0, 2'h1, 8'h02, 1, 0},
             '{3'h5, XFER_SINGLE, TYPE_READ,   1'b0, 2'h2, 8'h02, 3, 0},
             '{3'h6, XFER_SINGLE, TYPE_WRITE,  1'b1, 2'h0, 8'h01, 2, 2},
             '{3'h7, XFER_BLOCK,  TYPE_READ,   1'b0, 2'h1, 8'h01, 1, 0},
             '{3'h0, XFER_DEMAND, TYPE_WRITE,  1'b0, 2'h2, 8'h00, 1, 1},
             '{3'h3, XFER_SINGLE, TYPE_VERIFY, 1'b1, 2'h1, 8'h02, 3, 0}};
    do_reset();
    chk(state, ST_IDLE);
    for (int c = 0; c < 8; c++) begin
      cfg(c[2:0], `IDX_MODE, 8'h00, 1'b0);
      chk(v, 8'h00);
      cfg(c[2:0], `IDX_MASK, 8'h00, 1'b0);
      chk(v[0], 1'b1);
      cfg(c[2:0], `IDX_STATUS, 8'h00, 1'b0);
      chk(v[0], 1'b0);
    end
    foreach (rows[i]) begin
      r = rows[i];
      gdly = i[0] ? 4'h3 : 4'h0;
      prog(r.ch, {1'b0, r.tm, r.au, r.ty, r.xm}, r.cnt);
      stop_at = (r.xm == XFER_SINGLE) ? r.rises : 0;
      dreq[r.ch] = 1'b1;
      settle();
      {dreq, stop_at} = '0;
      chk(rises, r.rises);
      chk(words, r.words);
      if (r.tm != 2'h2 && r.ty != TYPE_VERIFY)
        chk({ior_n != 0, iow_n != 0}, {r.ty == TYPE_WRITE, r.ty == TYPE_READ});
      cfg(r.ch, `IDX_STATUS, 8'h00, 1'b0);
      chk(v[0], 1'b1);
      cfg(r.ch, `IDX_MASK, 8'h00, 1'b0);
      chk(v[0], !r.au);
      if (r.au) begin
        cfg(r.ch, `IDX_COUNT_LO, 8'h00, 1'b0);
        chk(v, r.cnt);
      end
    end
    // Request and index write land on the same edge
    {rises, stop_at} = {32'd0, 32'd2};
    @(negedge clk);
    dreq[6] = 1'b1;
    {io_sel, io_wr, io_addr, io_wdata} = {2'b11, `CFG_INDEX_PORT_ADDR, 8'h66};
    @(negedge clk);
    chk(state, ST_PROGRAM);
    io(`CFG_INDEX_PORT_ADDR, 8'h66, 1'b1);
    io(`CFG_DATA_PORT_ADDR, 8'h00, 1'b0);
    io_sel = 1'b0;
    settle();
    {dreq, stop_at} = '0;
    chk(rises, 2);
    prog(3'h1, {6'h00, XFER_CASCADE}, 8'h05);
    dreq[1] = 1'b1;
    wait_dack(8'h02);
    chk(dack, 8'h02);
    dreq = 8'h00;
    wait_dack(8'h00);
    chk({dack, words[7:0]}, 16'h0000);
    prog(3'h4, {4'h0, TYPE_WRITE, XFER_BLOCK}, 8'h01);
    dreq[4] = 1'b1;
    repeat (20) @(negedge clk);
    chk({dack, state}, {8'h00, ST_IDLE});
    dreq = 8'h00;
    gdly = 4'h3;
    prog(3'h2, {4'h2, TYPE_WRITE, XFER_DEMAND}, 8'h09);
    dreq[2] = 1'b1;
    for (int i = 0; i < 500 && words < 3; i++) @(negedge clk);
    dreq = 8'h00;
    settle();
    cfg(3'h2, `IDX_STATUS, 8'h00, 1'b0);
    chk(v[0], 1'b0);
    dreq[2] = 1'b1;
    settle();
    dreq = 8'h00;
    chk(rises, 2);
    chk(words, 10);
    prog(3'h5, {4'h0, TYPE_WRITE, XFER_BLOCK}, 8'h09);
    cfg(3'h5, `IDX_ADDR_LO, 8'h40, 1'b1);
    {eop, dreq[5]} = 2'b11;
    wait_dack(8'h20);
    chk(mem_addr, 16'h0040);
    settle();
    {eop, dreq} = 9'h000;
    chk(words, 1);
    chk(xd_q, 16'h5a3c);
    cfg(3'h5, `IDX_ADDR_LO, 8'h00, 1'b0);
    chk(v, 8'h41);
    xr = 1'b0;
    prog(3'h7, {4'h0, TYPE_WRITE, XFER_BLOCK}, 8'h13);
    dreq[7] = 1'b1;
    repeat (300) @(negedge clk);
    chk({xv, state}, {1'b1, ST_ACTIVE});
    xr = 1'b1;
    settle();
    dreq = 8'h00;
    chk({xv, words[7:0]}, {1'b0, 8'd20});
    prog(3'h1, {4'h0, TYPE_WRITE, XFER_BLOCK}, 8'h32);
    dreq[1] = 1'b1;
    wait_dack(8'h02);
    do_reset();
    dreq = 8'h00;
    cfg(3'h1, `IDX_MASK, 8'h00, 1'b0);
    chk(v[0], 1'b1);
    summarize();
  end
endmodule
